//--- src/lcd_cmd_pkg.sv
// Purpose: shared constants for the LCD bias and temperature command path
// Assumes: one 25 MHz clock, synchronous active-low reset
// Notes: command bytes qualified by rw flag 0 and register_select 11
package lcd_cmd_pkg;
  localparam logic [1:0] RS_CMD = 2'h3;
  localparam logic [2:0] OP_CHAR_HI = 3'h5;
  localparam logic [3:0] OP_CHAR_LO = 4'h9;
  localparam logic [2:0] OP_ICON_HI = 3'h6;
  localparam logic [3:0] OP_ICON_LO = 4'he;
  localparam logic [4:0] OP_TEMP_CTRL = 5'h00;
  localparam logic [4:0] OP_SLOPE_A = 5'h01;
  localparam logic [4:0] OP_SLOPE_B = 5'h02;
  localparam logic [4:0] OP_SLOPE_C = 5'h03;
  localparam logic [4:0] OP_SLOPE_D = 5'h04;
  localparam int TC_COMP_BIT = 2;
  localparam int TC_FILT_BIT = 1;
  localparam int TC_MEAS_BIT = 0;
  localparam logic [8:0] VCODE_RESET = 9'h000;
  localparam logic [2:0] TCTRL_RESET = 3'h0;
  localparam logic [2:0] SLOPE_RESET = 3'h0;
  localparam int FILTER_SHIFT = 2;
  // Host port registers, chosen offsets
  localparam logic [3:0] ADDR_CMD = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_INIT = 4'h2;
endpackage

//--- src/lcd_cmd_if.sv
`timescale 1ns/1ps
// Purpose: command byte link between host end and device end
// Assumes: one clock, byte valid for one cycle
// Notes: no back-pressure, device accepts every byte
interface lcd_cmd_if;
  logic cmd_valid;
  logic rw_flag;
  logic [1:0] register_select;
  logic [7:0] cmd_byte;
  logic init_cmd;
  modport host (output cmd_valid, output rw_flag, output register_select, output cmd_byte, output init_cmd);
  modport device (input cmd_valid, input rw_flag, input register_select, input cmd_byte, input init_cmd);
endinterface

//--- src/lcd_cmd_host.sv
`timescale 1ns/1ps
// Purpose: host end, issues command bytes from a register port
// Assumes: synchronous master, strobes one cycle
// Notes: write to ADDR_CMD sends byte; ADDR_INIT sends initialize
module lcd_cmd_host
  import lcd_cmd_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [15:0] rdata,
  lcd_cmd_if.host link
);
  import lcd_cmd_pkg::*;
  logic valid_r;
  logic rw_r;
  logic [1:0] rs_r;
  logic [7:0] byte_r;
  logic init_r;
  logic [15:0] count_r;
  // ==================================================
  // Command issue
  always_ff @(posedge clock) begin
    if (!rstn) begin
      valid_r <= 1'b0;
      rw_r <= 1'b0;
      rs_r <= 2'h0;
      byte_r <= 8'h00;
      init_r <= 1'b0;
    end else begin
      valid_r <= wr_stb && addr == ADDR_CMD;
      init_r <= wr_stb && addr == ADDR_INIT;
      if (wr_stb && addr == ADDR_CMD) begin
        byte_r <= wdata[7:0];
        rs_r <= wdata[9:8];
        rw_r <= wdata[10];
      end
    end
  end
  // ==================================================
  // Status readback
  always_ff @(posedge clock) begin
    if (!rstn) begin
      count_r <= 16'h0000;
      rdata <= 16'h0000;
    end else begin
      if (valid_r) begin
        count_r <= count_r + 16'h0001;
      end
      if (rd_stb) begin
        rdata <= (addr == ADDR_STATUS) ? count_r : 16'h0000;
      end else begin
        rdata <= 16'h0000;
      end
    end
  end
  assign link.cmd_valid = valid_r;
  assign link.rw_flag = rw_r;
  assign link.register_select = rs_r;
  assign link.cmd_byte = byte_r;
  assign link.init_cmd = init_r;
endmodule

//--- src/lcd_cmd_device.sv
`timescale 1ns/1ps
// Purpose: device end, decodes command bytes into bias and temperature settings
// Assumes: temperature samples arrive as one-cycle pulses
// Notes: compensation arithmetic lives outside; this block gates its inputs
module lcd_cmd_device
  import lcd_cmd_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  lcd_cmd_if.device link,
  input wire logic icon_mode_bit,
  input wire logic temp_sample_valid,
  input wire logic [7:0] temp_sample,
  output logic [8:0] char_mode_voltage_code,
  output logic [8:0] icon_mode_voltage_code,
  output logic [8:0] generator_code,
  output logic compensation_enable,
  output logic filter_enable,
  output logic measurement_enable,
  output logic comp_active,
  output logic [2:0] slope_factor_a,
  output logic [2:0] slope_factor_b,
  output logic [2:0] slope_factor_c,
  output logic [2:0] slope_factor_d,
  output logic [7:0] measured_temperature,
  output logic temp_readout_valid
);
  import lcd_cmd_pkg::*;
  logic qual;
  logic [7:0] b;
  logic [2:0] tctrl_r;
  logic [8:0] char_r;
  logic [8:0] icon_r;
  logic [2:0] slope_r [4];
  logic [8:0] gen_r;
  logic [7:0] temp_r;
  logic [9:0] acc_r;
  logic [9:0] acc_nxt;
  logic tvalid_r;
  assign qual = link.cmd_valid && !link.rw_flag && link.register_select == RS_CMD;
  assign b = link.cmd_byte;
  // ==================================================
  // Voltage codes, halves written separately
  always_ff @(posedge clock) begin
    if (!rstn) begin
      char_r <= VCODE_RESET;
      icon_r <= VCODE_RESET;
    end else if (qual) begin
      if (b[7:5] == OP_CHAR_HI) char_r[8:4] <= b[4:0];
      if (b[7:4] == OP_CHAR_LO) char_r[3:0] <= b[3:0];
      if (b[7:5] == OP_ICON_HI) icon_r[8:4] <= b[4:0];
      if (b[7:4] == OP_ICON_LO) icon_r[3:0] <= b[3:0];
    end
  end
  // ==================================================
  // Temperature control enables
  always_ff @(posedge clock) begin
    if (!rstn) begin
      tctrl_r <= TCTRL_RESET;
    end else if (link.init_cmd) begin
      tctrl_r <= TCTRL_RESET;
    end else if (qual && b[7:3] == OP_TEMP_CTRL) begin
      tctrl_r <= b[2:0];
    end
  end
  // ==================================================
  // Slope factors, indexed by opcode
  generate
    for (genvar i = 0; i < 4; i++) begin : g_slope
      always_ff @(posedge clock) begin
        if (!rstn) begin
          slope_r[i] <= SLOPE_RESET;
        end else if (qual && b[7:3] == OP_SLOPE_A + 5'(i)) begin
          slope_r[i] <= b[2:0];
        end
      end
    end
  endgenerate
  // ==================================================
  // Generator code select
  always_ff @(posedge clock) begin
    if (!rstn) begin
      gen_r <= VCODE_RESET;
    end else begin
      gen_r <= icon_mode_bit ? icon_r : char_r;
    end
  end
  // ==================================================
  // Temperature path; filter is a simple first-order average
  always_comb begin
    acc_nxt = acc_r - {2'h0, acc_r[9:2]} + {2'h0, temp_sample};
  end
  always_ff @(posedge clock) begin
    if (!rstn) begin
      temp_r <= 8'h00;
      acc_r <= 10'h000;
      tvalid_r <= 1'b0;
    end else if (!tctrl_r[TC_MEAS_BIT]) begin
      tvalid_r <= 1'b0;
      temp_r <= 8'h00;
    end else if (temp_sample_valid) begin
      tvalid_r <= 1'b1;
      if (tctrl_r[TC_FILT_BIT]) begin
        acc_r <= acc_nxt;
        temp_r <= acc_nxt[9:2];
      end else begin
        acc_r <= {temp_sample, 2'h0};
        temp_r <= temp_sample;
      end
    end
  end
  assign char_mode_voltage_code = char_r;
  assign icon_mode_voltage_code = icon_r;
  assign generator_code = gen_r;
  assign compensation_enable = tctrl_r[TC_COMP_BIT];
  assign filter_enable = tctrl_r[TC_FILT_BIT];
  assign measurement_enable = tctrl_r[TC_MEAS_BIT];
  assign comp_active = tctrl_r[TC_COMP_BIT] && tctrl_r[TC_MEAS_BIT];
  assign slope_factor_a = slope_r[0];
  assign slope_factor_b = slope_r[1];
  assign slope_factor_c = slope_r[2];
  assign slope_factor_d = slope_r[3];
  assign measured_temperature = temp_r;
  assign temp_readout_valid = tvalid_r;
endmodule

//--- bench/lcd_cmd_props.sv
// Purpose: link-side checks of the command decoder
// Assumes: one clock, sync active-low reset
// Notes: fields load at the edge after a byte
`timescale 1ns/1ps
module lcd_cmd_props
  import lcd_cmd_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic cmd_valid,
  input wire logic rw_flag,
  input wire logic [1:0] register_select,
  input wire logic [7:0] cmd_byte,
  input wire logic init_cmd,
  input wire logic [8:0] char_mode_voltage_code,
  input wire logic [8:0] icon_mode_voltage_code,
  input wire logic compensation_enable,
  input wire logic filter_enable,
  input wire logic measurement_enable
);
  logic q;
  assign q = cmd_valid && !rw_flag && register_select == RS_CMD;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // ==========
  // Loads, holds and init clear
  a_char_hi_load: assert property (q && cmd_byte[7:5] == OP_CHAR_HI
    |=> char_mode_voltage_code[8:4] == $past(cmd_byte[4:0])) else $error("char hi");
  a_char_lo_load: assert property (q && cmd_byte[7:4] == OP_CHAR_LO
    |=> char_mode_voltage_code[3:0] == $past(cmd_byte[3:0])) else $error("char lo");
  a_icon_hi_load: assert property (q && cmd_byte[7:5] == OP_ICON_HI
    |=> icon_mode_voltage_code[8:4] == $past(cmd_byte[4:0])) else $error("icon hi");
  a_icon_lo_load: assert property (q && cmd_byte[7:4] == OP_ICON_LO
    |=> icon_mode_voltage_code[3:0] == $past(cmd_byte[3:0])) else $error("icon lo");
  a_lo_keeps_hi: assert property (q && cmd_byte[7:4] == OP_CHAR_LO
    |=> $stable(char_mode_voltage_code[8:4])) else $error("hi half moved");
  a_codes_hold: assert property (!q
    |=> $stable(char_mode_voltage_code) && $stable(icon_mode_voltage_code)) else $error("code moved");
  a_temp_ctrl_load: assert property (q && cmd_byte[7:3] == OP_TEMP_CTRL && !init_cmd
    |=> {compensation_enable, filter_enable, measurement_enable} == $past(cmd_byte[2:0])) else $error("temp ctrl");
  a_init_clears: assert property (init_cmd
    |=> !compensation_enable && !filter_enable && !measurement_enable) else $error("init");
endmodule

//--- bench/tb.sv
// Purpose: host-port driven bench of both ends
// Assumes: 25 MHz clock
// Notes: waits are fixed by the link latency
`timescale 1ns/1ps
module tb;
  import lcd_cmd_pkg::*;
  logic clock = 0, rstn = 0, wr_stb = 0, rd_stb = 0, icon_mode_bit = 0, temp_sample_valid = 0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata;
  logic [7:0] temp_sample = 8'h00, measured_temperature;
  logic [8:0] char_mode_voltage_code, icon_mode_voltage_code, generator_code;
  logic compensation_enable, filter_enable, measurement_enable, comp_active, temp_readout_valid;
  logic [2:0] slope_factor_a, slope_factor_b, slope_factor_c, slope_factor_d;
  int failures = 0, n_compared = 0;
  lcd_cmd_if lnk();
  lcd_cmd_host u_lcd_cmd_host(.clock, .rstn, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .link(lnk.host));
  lcd_cmd_device u_lcd_cmd_device(.clock, .rstn, .link(lnk.device), .icon_mode_bit, .temp_sample_valid,
    .temp_sample, .char_mode_voltage_code, .icon_mode_voltage_code, .generator_code, .compensation_enable,
    .filter_enable, .measurement_enable, .comp_active, .slope_factor_a, .slope_factor_b, .slope_factor_c,
    .slope_factor_d, .measured_temperature, .temp_readout_valid);
  lcd_cmd_props u_lcd_cmd_props(.clock, .rstn, .cmd_valid(lnk.cmd_valid), .rw_flag(lnk.rw_flag),
    .register_select(lnk.register_select), .cmd_byte(lnk.cmd_byte), .init_cmd(lnk.init_cmd),
    .char_mode_voltage_code, .icon_mode_voltage_code, .compensation_enable, .filter_enable, .measurement_enable);
  initial forever #20 clock = ~clock;
  // ==========
  // Tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask
  // Wire view checked one cycle after the host write
  task automatic cmd(input logic rw, input logic [1:0] rs, input logic [7:0] b);
    wr(ADDR_CMD, {5'h00, rw, rs, b});
    #1 chk({lnk.cmd_valid, lnk.rw_flag, lnk.register_select, lnk.cmd_byte}, {4'h0, 1'b1, rw, rs, b});
    repeat (2) @(posedge clock);
    #1;
  endtask
  task automatic rd(input logic [15:0] exp);
    @(posedge clock);
    addr <= ADDR_STATUS;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic finish_test;
    $display("failures=%0d n_compared=%0d", failures, n_compared);
    if (failures == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clock);
    failures++;
    finish_test;
  end
  // ==========
  // Sequence
  initial begin
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    #1 chk({char_mode_voltage_code, compensation_enable, filter_enable, measurement_enable}, 16'h0000);
    cmd(1'b0, RS_CMD, 8'ha5);
    chk(char_mode_voltage_code, 16'h0050);
    cmd(1'b0, RS_CMD, 8'h9c);
    chk(char_mode_voltage_code, 16'h005c);
    cmd(1'b0, RS_CMD, 8'hdf);
    cmd(1'b0, RS_CMD, 8'he3);
    chk({icon_mode_voltage_code, generator_code[0]}, 16'h03e6);
    cmd(1'b1, RS_CMD, 8'hbf);
    cmd(1'b0, 2'h2, 8'h9f);
    chk(char_mode_voltage_code, 16'h005c);
    @(posedge clock);
    icon_mode_bit <= 1'b1;
    repeat (3) @(posedge clock);
    #1 chk(generator_code, 16'h01f3);
    for (int i = 0; i < 4; i++) begin
      cmd(1'b0, RS_CMD, {5'(i + 1), 3'(7 - i)});
    end
    chk({slope_factor_a, slope_factor_b, slope_factor_c, slope_factor_d}, 16'h0fac);
    rd(16'h000a);
    cmd(1'b0, RS_CMD, 8'h07);
    chk({compensation_enable, filter_enable, measurement_enable, comp_active}, 16'h000f);
    wr(ADDR_INIT, 16'h0000);
    repeat (2) @(posedge clock);
    #1 chk({compensation_enable, filter_enable, measurement_enable}, 16'h0000);
    cmd(1'b0, RS_CMD, 8'h01);
    @(posedge clock);
    temp_sample <= 8'h3c;
    temp_sample_valid <= 1'b1;
    @(posedge clock);
    temp_sample_valid <= 1'b0;
    repeat (2) @(posedge clock);
    #1 chk({temp_readout_valid, measured_temperature}, 16'h013c);
    cmd(1'b0, RS_CMD, 8'h00);
    chk({temp_readout_valid, measured_temperature}, 16'h0000);
    cmd(1'b0, RS_CMD, 8'h04);
    chk({compensation_enable, filter_enable, measurement_enable, comp_active}, 16'h0008);
    // Average seeded by the last unfiltered sample of 3c
    cmd(1'b0, RS_CMD, 8'h03);
    @(posedge clock);
    temp_sample <= 8'h80;
    temp_sample_valid <= 1'b1;
    @(posedge clock);
    temp_sample_valid <= 1'b0;
    repeat (2) @(posedge clock);
    #1 chk({temp_readout_valid, measured_temperature}, 16'h014d);
    finish_test;
  end
endmodule
